// ### hdl/dtec_regs.vh
// Register map, field positions, mode codes and reset values of the dual timer
`ifndef DTEC_REGS_VH
`define DTEC_REGS_VH

// Bus widths
`define DTEC_AW 12
`define DTEC_DW 32

// Register indices; byte address is four times the index
`define DTEC_IDX_TIMER_RUN_AND_FLAG_CONTROL 8'h88
`define DTEC_IDX_TIMER_MODE_CONTROL 8'h89
`define DTEC_IDX_TL0 8'h8A
`define DTEC_IDX_TL1 8'h8B
`define DTEC_IDX_TH0 8'h8C
`define DTEC_IDX_TH1 8'h8D

// Mode control fields
`define DTEC_T1_GATE 7
`define DTEC_T1_SRC 6
`define DTEC_T1_MHI 5
`define DTEC_T1_MLO 4
`define DTEC_T0_GATE 3
`define DTEC_T0_SRC 2
`define DTEC_T0_MHI 1
`define DTEC_T0_MLO 0

// Run and flag control fields
`define DTEC_TF1 7
`define DTEC_TR1 6
`define DTEC_TF0 5
`define DTEC_TR0 4
`define DTEC_IE1 3
`define DTEC_IT1 2
`define DTEC_IE0 1
`define DTEC_IT0 0

// Counter modes
`define DTEC_MODE13 2'h0
`define DTEC_MODE16 2'h1
`define DTEC_MODE8R 2'h2
`define DTEC_MODESPLIT 2'h3

// Counter constants
`define DTEC_ONES13 13'h1FFF
`define DTEC_ONES16 16'hFFFF
`define DTEC_ONES8 8'hFF
`define DTEC_INC13 13'h0001
`define DTEC_INC16 16'h0001
`define DTEC_INC8 8'h01

// Interrupt request line numbers
`define DTEC_IRQ_EXT0 0
`define DTEC_IRQ_TMR0 1
`define DTEC_IRQ_EXT1 2
`define DTEC_IRQ_TMR1 3

// Synchronised input numbers
`define DTEC_PIN_EV0 0
`define DTEC_PIN_EV1 1
`define DTEC_PIN_IRQ0 2
`define DTEC_PIN_IRQ1 3
`define DTEC_NPIN 4

// Reset values
`define DTEC_RST8 8'h00
`define DTEC_RST32 32'h0000_0000

`endif

// ### hdl/dtec_edge_detect.v
// Two-stage input synchroniser with falling-edge detector
`timescale 1ns/10ps
`default_nettype none

module dtec_edge_detect
(
   // Clock, reset, enable
   input wire clk,
   input wire rstN,
   input wire clkEn,
   // Raw pin
   input wire pinIn,
   // Synchronised level and one-cycle falling pulse
   output wire level,
   output wire fall
);

   reg syncA; // First stage, read by second stage only
   reg syncB; // Second stage
   reg prevB; // Previous sample of second stage

   // Two flops, then one more for edge compare
   always @(posedge clk or negedge rstN)
   begin
      if (!rstN)
      begin
         syncA <= 1'b1;
         syncB <= 1'b1;
         prevB <= 1'b1;
      end
      else if (clkEn)
      begin
         syncA <= pinIn;
         syncB <= syncA;
         prevB <= syncB;
      end
   end

   // High to low seen between two samples
   assign fall = prevB & ~syncB & clkEn;
   assign level = syncB;

endmodule // dtec_edge_detect

`default_nettype wire

// ### hdl/dtec_timer_top.v
// Dual timer / event counter with external interrupt flags and APB registers
//
// The APB interface to the registers is this design's own decision.
`timescale 1ns/10ps
`default_nettype none
`include "dtec_regs.vh"

// Notes on behaviour
// - Timer mode counts every clock when enabled
// - Counter mode counts falling event input edges
// - Gating needs run bit and high pin
// - Source select picks event input or clock
// - Two-bit mode field per timer decoded
// - Mode 0 uses high byte plus five
// - Rollover to zero sets overflow flag
// - Run bit never touches count registers
// - Mode 1 is a plain 16-bit counter
// - Mode 2 reloads low from high byte
// - Timer 1 mode 3 holds its count
// - Split low byte uses timer 0 controls
// - Split high byte uses timer 1 run/flag
// - Timer 1 runs silently during split mode
// - Overflow flags cleared by ack or software
// - Run bits at control bits 6, 4
// - Type bit picks edge or level request
// - Type bits at control bits 2, 0
// - Four request lines in fixed order
// - Mode register at 89H, resets zero
// - Ack clears only edge-type external flags
module dtec_timer_top
(
   // Clock, reset, enable
   input wire clk,
   input wire reset_n,
   input wire clkEn,
   // APB slave
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [`DTEC_AW-1:0] paddr,
   input wire [`DTEC_DW-1:0] pwdata,
   output reg [`DTEC_DW-1:0] prdata,
   output wire pready,
   output reg pslverr,
   // Pins
   input wire ctr0EventIn,
   input wire ctr1EventIn,
   input wire extIrq0Pin_n,
   input wire extIrq1Pin_n,
   // Interrupt controller
   input wire [3:0] irqAck,
   output wire irqLine0,
   output wire irqLine1,
   output wire irqLine2,
   output wire irqLine3
);

   reg rstMeta; // Reset synchroniser first stage
   reg rstSyncN; // Released reset for all logic

   // Registers
   reg [7:0] timerModeControl; // Mode control
   reg [7:0] timer0CountLow; // Timer 0 low byte
   reg [7:0] timer0CountHigh; // Timer 0 high byte
   reg [7:0] timer1CountLow; // Timer 1 low byte
   reg [7:0] timer1CountHigh; // Timer 1 high byte
   reg ctr0Run; // Timer 0 run
   reg ctr1Run; // Timer 1 run
   reg ctr0OverflowFlag; // Timer 0 overflow
   reg ctr1OverflowFlag; // Timer 1 overflow
   reg extIrq0Flag; // External request 0
   reg extIrq1Flag; // External request 1
   reg extIrq0Type; // 1: edge, 0: level
   reg extIrq1Type; // 1: edge, 0: level

   // Synchronised pins
   wire [`DTEC_NPIN-1:0] pinRaw;
   wire [`DTEC_NPIN-1:0] pinLevel;
   wire [`DTEC_NPIN-1:0] pinFall;

   // Mode control fields
   wire ctr0Gating = timerModeControl[`DTEC_T0_GATE];
   wire ctr1Gating = timerModeControl[`DTEC_T1_GATE];
   wire ctr0SourceSelect = timerModeControl[`DTEC_T0_SRC];
   wire ctr1SourceSelect = timerModeControl[`DTEC_T1_SRC];
   wire [1:0] ctr0Mode = {timerModeControl[`DTEC_T0_MHI], timerModeControl[`DTEC_T0_MLO]};
   wire [1:0] ctr1Mode = {timerModeControl[`DTEC_T1_MHI], timerModeControl[`DTEC_T1_MLO]};

   // Count enables
   wire ctr0Enable;
   wire ctr1Enable;
   wire tick0;
   wire tick1;
   wire splitMode;
   wire splitTick;

   // Next values
   reg [7:0] next_tl0;
   reg [7:0] next_th0;
   reg [7:0] next_tl1;
   reg [7:0] next_th1;
   reg setTf0;
   reg setTf1;
   reg [16:0] step0;
   reg [16:0] step1;

   // Bus decode
   wire setupPhase;
   wire writeAccess;
   wire hitTcon;
   wire hitTmod;
   wire hitTl0;
   wire hitTl1;
   wire hitTh0;
   wire hitTh1;
   wire anyHit;
   wire [7:0] wrByte;
   reg [7:0] tconValue;
   reg [7:0] readByte;

   // One counting step for modes 0, 1, 2; default is plain 8-bit low byte
   // Returns {overflow, high, low}
   function [16:0] cntStep;
      input [1:0] mode;
      input [7:0] hi;
      input [7:0] lo;
      reg [12:0] c13;
      reg [15:0] c16;
      begin
         c13 = {hi, lo[4:0]};
         c16 = {hi, lo};
         case (mode)
            `DTEC_MODE13:
            begin
               // Upper three low-byte bits left as they are
               c13 = c13 + `DTEC_INC13;
               cntStep = {({hi, lo[4:0]} == `DTEC_ONES13), c13[12:5], lo[7:5], c13[4:0]};
            end
            `DTEC_MODE16:
            begin
               c16 = c16 + `DTEC_INC16;
               cntStep = {({hi, lo} == `DTEC_ONES16), c16};
            end
            `DTEC_MODE8R:
            begin
               // Low byte overflow reloads from high byte
               if (lo == `DTEC_ONES8)
                  cntStep = {1'b1, hi, hi};
               else
                  cntStep = {1'b0, hi, lo + `DTEC_INC8};
            end
            default:
            begin
               // Free 8-bit low byte, high byte untouched
               cntStep = {(lo == `DTEC_ONES8), hi, lo + `DTEC_INC8};
            end
         endcase
      end
   endfunction

   // Reset release through two flops
   always @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         rstMeta <= 1'b0;
         rstSyncN <= 1'b0;
      end
      else
      begin
         rstMeta <= 1'b1;
         rstSyncN <= rstMeta;
      end
   end

   // Pin synchronisers and edge detectors
   assign pinRaw = {extIrq1Pin_n, extIrq0Pin_n, ctr1EventIn, ctr0EventIn};

   genvar gi;
   generate
      for (gi = 0; gi < `DTEC_NPIN; gi = gi + 1)
      begin : gPin
         dtec_edge_detect uEdge
         (
            .clk(clk),
            .rstN(rstSyncN),
            .clkEn(clkEn),
            .pinIn(pinRaw[gi]),
            .level(pinLevel[gi]),
            .fall(pinFall[gi])
         );
      end
   endgenerate

   // Run bit, optionally gated by external pin held high
   assign ctr0Enable = ctr0Run & (~ctr0Gating | pinLevel[`DTEC_PIN_IRQ0]);
   assign ctr1Enable = ctr1Run & (~ctr1Gating | pinLevel[`DTEC_PIN_IRQ1]);

   // Source: clock every cycle, or event falling edge
   assign tick0 = clkEn & ctr0Enable & (ctr0SourceSelect ? pinFall[`DTEC_PIN_EV0] : 1'b1);
   // Timer 1 in its own mode 3 acts as stopped
   assign tick1 = clkEn & ctr1Enable & (ctr1Mode != `DTEC_MODESPLIT)
      & (ctr1SourceSelect ? pinFall[`DTEC_PIN_EV1] : 1'b1);

   // Split high byte counts clocks under timer 1 run bit
   assign splitMode = (ctr0Mode == `DTEC_MODESPLIT);
   assign splitTick = clkEn & splitMode & ctr1Run;

   // Counter next values and overflow events
   always @*
   begin
      step0 = cntStep(ctr0Mode, timer0CountHigh, timer0CountLow);
      step1 = cntStep(ctr1Mode, timer1CountHigh, timer1CountLow);
      next_tl0 = timer0CountLow;
      next_th0 = timer0CountHigh;
      next_tl1 = timer1CountLow;
      next_th1 = timer1CountHigh;
      setTf0 = 1'b0;
      setTf1 = 1'b0;
      // Timer 0 (low byte only in split mode)
      if (tick0)
      begin
         next_th0 = step0[15:8];
         next_tl0 = step0[7:0];
         setTf0 = step0[16];
      end
      // Split high byte, owns timer 1 flag
      if (splitTick)
      begin
         next_th0 = timer0CountHigh + `DTEC_INC8;
         setTf1 = (timer0CountHigh == `DTEC_ONES8);
      end
      // Timer 1, silent while timer 0 is split
      if (tick1)
      begin
         next_th1 = step1[15:8];
         next_tl1 = step1[7:0];
         if (!splitMode)
            setTf1 = step1[16];
      end
   end

   // APB decode, zero wait states
   assign setupPhase = psel & ~penable;
   assign writeAccess = psel & penable & pwrite & clkEn;
   assign hitTcon = (paddr == {2'h0, `DTEC_IDX_TIMER_RUN_AND_FLAG_CONTROL, 2'h0});
   assign hitTmod = (paddr == {2'h0, `DTEC_IDX_TIMER_MODE_CONTROL, 2'h0});
   assign hitTl0 = (paddr == {2'h0, `DTEC_IDX_TL0, 2'h0});
   assign hitTl1 = (paddr == {2'h0, `DTEC_IDX_TL1, 2'h0});
   assign hitTh0 = (paddr == {2'h0, `DTEC_IDX_TH0, 2'h0});
   assign hitTh1 = (paddr == {2'h0, `DTEC_IDX_TH1, 2'h0});
   assign anyHit = hitTcon | hitTmod | hitTl0 | hitTl1 | hitTh0 | hitTh1;
   assign wrByte = pwdata[7:0];
   assign pready = 1'b1;

   // Run and flag register image
   always @*
   begin
      tconValue = `DTEC_RST8;
      tconValue[`DTEC_TF1] = ctr1OverflowFlag;
      tconValue[`DTEC_TR1] = ctr1Run;
      tconValue[`DTEC_TF0] = ctr0OverflowFlag;
      tconValue[`DTEC_TR0] = ctr0Run;
      tconValue[`DTEC_IE1] = extIrq1Flag;
      tconValue[`DTEC_IT1] = extIrq1Type;
      tconValue[`DTEC_IE0] = extIrq0Flag;
      tconValue[`DTEC_IT0] = extIrq0Type;
   end

   // Read multiplexer
   always @*
   begin
      case (1'b1)
         hitTcon: readByte = tconValue;
         hitTmod: readByte = timerModeControl;
         hitTl0: readByte = timer0CountLow;
         hitTl1: readByte = timer1CountLow;
         hitTh0: readByte = timer0CountHigh;
         hitTh1: readByte = timer1CountHigh;
         default: readByte = `DTEC_RST8;
      endcase
   end

   // Read data and error captured in the setup cycle
   always @(posedge clk or negedge rstSyncN)
   begin
      if (!rstSyncN)
      begin
         prdata <= `DTEC_RST32;
         pslverr <= 1'b0;
      end
      else if (clkEn && setupPhase)
      begin
         prdata <= {24'h00_0000, readByte};
         pslverr <= ~anyHit;
      end
   end

   // Mode and run/type control bits
   always @(posedge clk or negedge rstSyncN)
   begin
      if (!rstSyncN)
      begin
         timerModeControl <= `DTEC_RST8;
         ctr0Run <= 1'b0;
         ctr1Run <= 1'b0;
         extIrq0Type <= 1'b0;
         extIrq1Type <= 1'b0;
      end
      else if (writeAccess)
      begin
         if (hitTmod)
            timerModeControl <= wrByte;
         // Run and type bits only; counts are left alone
         if (hitTcon)
         begin
            ctr1Run <= wrByte[`DTEC_TR1];
            ctr0Run <= wrByte[`DTEC_TR0];
            extIrq1Type <= wrByte[`DTEC_IT1];
            extIrq0Type <= wrByte[`DTEC_IT0];
         end
      end
   end

   // Overflow flags: hardware set beats ack and software clear
   always @(posedge clk or negedge rstSyncN)
   begin
      if (!rstSyncN)
      begin
         ctr0OverflowFlag <= 1'b0;
         ctr1OverflowFlag <= 1'b0;
      end
      else if (clkEn)
      begin
         ctr0OverflowFlag <= setTf0 | (~irqAck[`DTEC_IRQ_TMR0]
            & ((writeAccess & hitTcon) ? wrByte[`DTEC_TF0] : ctr0OverflowFlag));
         ctr1OverflowFlag <= setTf1 | (~irqAck[`DTEC_IRQ_TMR1]
            & ((writeAccess & hitTcon) ? wrByte[`DTEC_TF1] : ctr1OverflowFlag));
      end
   end

   // External request flags: edge latched, or level followed
   always @(posedge clk or negedge rstSyncN)
   begin
      if (!rstSyncN)
      begin
         extIrq0Flag <= 1'b0;
         extIrq1Flag <= 1'b0;
      end
      else if (clkEn)
      begin
         // Request 0
         if (extIrq0Type)
            extIrq0Flag <= pinFall[`DTEC_PIN_IRQ0] | (~irqAck[`DTEC_IRQ_EXT0]
               & ((writeAccess & hitTcon) ? wrByte[`DTEC_IE0] : extIrq0Flag));
         else
            extIrq0Flag <= ~pinLevel[`DTEC_PIN_IRQ0];
         // Request 1
         if (extIrq1Type)
            extIrq1Flag <= pinFall[`DTEC_PIN_IRQ1] | (~irqAck[`DTEC_IRQ_EXT1]
               & ((writeAccess & hitTcon) ? wrByte[`DTEC_IE1] : extIrq1Flag));
         else
            extIrq1Flag <= ~pinLevel[`DTEC_PIN_IRQ1];
      end
   end

   // Count registers: software write beats counting
   always @(posedge clk or negedge rstSyncN)
   begin
      if (!rstSyncN)
      begin
         timer0CountLow <= `DTEC_RST8;
         timer0CountHigh <= `DTEC_RST8;
         timer1CountLow <= `DTEC_RST8;
         timer1CountHigh <= `DTEC_RST8;
      end
      else if (clkEn)
      begin
         timer0CountLow <= (writeAccess & hitTl0) ? wrByte : next_tl0;
         timer0CountHigh <= (writeAccess & hitTh0) ? wrByte : next_th0;
         timer1CountLow <= (writeAccess & hitTl1) ? wrByte : next_tl1;
         timer1CountHigh <= (writeAccess & hitTh1) ? wrByte : next_th1;
      end
   end

   // Request lines straight from flag flops
   assign irqLine0 = extIrq0Flag;
   assign irqLine1 = ctr0OverflowFlag;
   assign irqLine2 = extIrq1Flag;
   assign irqLine3 = ctr1OverflowFlag;

endmodule // dtec_timer_top

`default_nettype wire

// ### tb/dtec_timer_assertions.sv
// Port-level assertions for the dual timer block
`timescale 1ns/10ps
`default_nettype none
`include "dtec_regs.vh"
module dtec_timer_assertions
(
   // Clock, reset, enable
   input wire logic clk,
   input wire logic reset_n,
   input wire logic clkEn,
   // APB slave side
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [`DTEC_AW-1:0] paddr,
   input wire logic [`DTEC_DW-1:0] pwdata,
   input wire logic [`DTEC_DW-1:0] prdata,
   input wire logic pslverr,
   // Pins and request lines
   input wire logic extIrq0Pin_n,
   input wire logic extIrq1Pin_n,
   input wire logic [3:0] irqAck,
   input wire logic irqLine0,
   input wire logic irqLine1,
   input wire logic irqLine2,
   input wire logic irqLine3
);
   default clocking @(posedge clk); endclocking
   default disable iff (!reset_n);
   wire logic acc = psel && penable; // Access phase
   wire logic [9:0] word = paddr[11:2]; // Word index
   wire logic mapped = word >= {2'h0, `DTEC_IDX_TIMER_RUN_AND_FLAG_CONTROL} && word <= {2'h0, `DTEC_IDX_TH1}
      && paddr[1:0] == 2'h0; // Inside map, word aligned
   wire logic wrEdge = acc && pwrite && clkEn; // Write lands here
   wire logic tconWr = wrEdge && word == {2'h0, `DTEC_IDX_TIMER_RUN_AND_FLAG_CONTROL}; // Control write
   logic [7:0] modeShadow; // Last mode value written
   // Follow software writes to the mode register
   always @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
         modeShadow <= `DTEC_RST8;
      else if (wrEdge && word == {2'h0, `DTEC_IDX_TIMER_MODE_CONTROL})
         modeShadow <= pwdata[7:0];
   end
   chk_mode_readback: assert property (acc && !pwrite && word == {2'h0, `DTEC_IDX_TIMER_MODE_CONTROL} |-> prdata[7:0] == modeShadow)
      else $error("mode register read differs from last write");
   chk_err_decode: assert property (acc |-> pslverr == !mapped)
      else $error("error response does not match address decode");
   chk_ack_tmr0: assert property (clkEn && irqAck[1] |=> !irqLine1)
      else $error("timer 0 flag survived acknowledge");
   chk_ack_tmr1: assert property (clkEn && irqAck[3] |=> !irqLine3)
      else $error("timer 1 flag survived acknowledge");
   chk_swclr_tmr0: assert property (tconWr && !pwdata[`DTEC_TF0] |=> !irqLine1)
      else $error("timer 0 flag survived software clear");
   chk_swclr_tmr1: assert property (tconWr && !pwdata[`DTEC_TF1] |=> !irqLine3)
      else $error("timer 1 flag survived software clear");
   chk_flag_hold: assert property ($fell(irqLine1) |-> $past(irqAck[1]) || $past(tconWr))
      else $error("timer 0 flag dropped without a cause");
   chk_ext0_raise: assert property ($fell(extIrq0Pin_n) |-> ##[1:4] irqLine0)
      else $error("external request 0 not raised");
   chk_ext1_raise: assert property ($fell(extIrq1Pin_n) |-> ##[1:4] irqLine2)
      else $error("external request 1 not raised");
endmodule // dtec_timer_assertions
bind dtec_timer_top dtec_timer_assertions chk (.clk(clk), .reset_n(reset_n), .clkEn(clkEn), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pslverr(pslverr),
   .extIrq0Pin_n(extIrq0Pin_n), .extIrq1Pin_n(extIrq1Pin_n), .irqAck(irqAck), .irqLine0(irqLine0),
   .irqLine1(irqLine1), .irqLine2(irqLine2), .irqLine3(irqLine3));
`default_nettype wire

// ### tb/dtec_irq_model.sv
// Interrupt controller stand-in that acknowledges raised request lines
`timescale 1ns/10ps
`default_nettype none
module dtec_irq_model
(
   // Clock and reset
   input wire logic clk,
   input wire logic reset_n,
   // Bench controls
   input wire logic [3:0] ackEn,
   input wire logic slowAck,
   // Request lines and acknowledge
   input wire logic [3:0] irqLines,
   output logic [3:0] irqAck
);
   logic [2:0] waitCnt; // Cycles left before answering
   wire logic [3:0] pend = ackEn & irqLines; // Lines it may service
   // One-cycle acknowledge after a prompt or slow wait
   always @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         irqAck <= 4'h0;
         waitCnt <= 3'h0;
      end
      else if (pend == 4'h0 || irqAck != 4'h0)
      begin
         irqAck <= 4'h0;
         waitCnt <= slowAck ? 3'h5 : 3'h0;
      end
      else if (waitCnt != 3'h0)
         waitCnt <= waitCnt - 3'h1;
      else
         irqAck <= pend;
   end
endmodule // dtec_irq_model
`default_nettype wire

// ### tb/dtec_timer_top_tb_top.sv
// Self-checking bench for the dual timer block
`timescale 1ns/10ps
`default_nettype none
`include "dtec_regs.vh"
module dtec_timer_top_tb_top;
   localparam logic [7:0] lo0 = `DTEC_IDX_TL0; // Timer 0 low byte
   localparam logic [7:0] lo1 = `DTEC_IDX_TL1; // Timer 1 low byte
   localparam logic [7:0] ctl = `DTEC_IDX_TIMER_RUN_AND_FLAG_CONTROL; // Run and flag control
   localparam logic [7:0] mdr = `DTEC_IDX_TIMER_MODE_CONTROL; // Mode control
   logic clk, reset_n, clkEn, psel, penable, pwrite, err, slowAck; // Clock, reset, bus
   logic ctr0EventIn, ctr1EventIn, extIrq0Pin_n, extIrq1Pin_n; // Pins
   logic pready, pslverr, irqLine0, irqLine1, irqLine2, irqLine3; // Design outputs
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata;
   logic [3:0] irqAck, ackEn, lines;
   logic [7:0] b, ql, qh, qc, rd; // Base step count and read results
   logic [12:0] c13; // Expected 13-bit count
   logic [15:0] c16; // Expected 16-bit count
   int failures = 0, totalChecks = 0, cycles = 0;
   assign lines = {irqLine3, irqLine2, irqLine1, irqLine0};
   dtec_timer_top uut (.clk(clk), .reset_n(reset_n), .clkEn(clkEn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .ctr0EventIn(ctr0EventIn), .ctr1EventIn(ctr1EventIn), .extIrq0Pin_n(extIrq0Pin_n),
      .extIrq1Pin_n(extIrq1Pin_n), .irqAck(irqAck), .irqLine0(irqLine0), .irqLine1(irqLine1),
      .irqLine2(irqLine2), .irqLine3(irqLine3));
   dtec_irq_model ctrl (.clk(clk), .reset_n(reset_n), .ackEn(ackEn), .slowAck(slowAck), .irqLines(lines),
      .irqAck(irqAck));
   // 20 MHz clock
   initial
   begin
      clk = 1'h0;
      forever #25 clk = ~clk;
   end
   // Cut a hang short
   always @(posedge clk)
   begin
      cycles <= cycles + 1;
      if (cycles == 20000)
      begin
         failures++;
         tallyAndFinish;
      end
   end
   task automatic tallyAndFinish;
      $display("Checks %0d, mismatches %0d", totalChecks, failures);
      if (failures == 0 && totalChecks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   task automatic check8(input logic [7:0] got, input logic [7:0] exp);
      totalChecks++;
      if (got !== exp)
      begin
         failures++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // One APB transfer; read data lands in rd, error in err
   task automatic apb(input logic [7:0] idx, input logic wr, input logic [7:0] wd);
      @(posedge clk);
      psel <= 1'h1;
      pwrite <= wr;
      paddr <= {2'h0, idx, 2'h0};
      pwdata <= {24'h0, wd};
      @(posedge clk);
      penable <= 1'h1;
      @(posedge clk);
      while (pready !== 1'h1)
         @(posedge clk);
      rd = prdata[7:0];
      err = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
   endtask
   // Load a counter, run it for a gap, stop it and read it back
   task automatic meas(input logic [7:0] li, input logic [7:0] tm, input logic [7:0] run,
      input logic [7:0] l, input logic [7:0] h, input int gap, input logic ev);
      apb(li, 1'h1, l);
      apb(li + 8'h2, 1'h1, h);
      apb(mdr, 1'h1, tm);
      apb(ctl, 1'h1, run);
      for (int i = 0; i < gap; i++)
      begin
         @(posedge clk);
         if (ev)
         begin
            ctr0EventIn <= i[2];
            ctr1EventIn <= i[2];
         end
      end
      apb(ctl, 1'h0, 8'h00);
      qc = rd;
      apb(ctl, 1'h1, 8'h00);
      apb(li, 1'h0, 8'h00);
      ql = rd;
      apb(li + 8'h2, 1'h0, 8'h00);
      qh = rd;
   endtask
   task automatic pin(input int k, input logic v);
      if (k == 1)
         extIrq1Pin_n <= v;
      else
         extIrq0Pin_n <= v;
   endtask
   // Main sequence
   initial
   begin
      {reset_n, psel, penable, pwrite, slowAck, paddr, pwdata, ackEn} = '0;
      {clkEn, ctr0EventIn, ctr1EventIn, extIrq0Pin_n, extIrq1Pin_n} = 5'h1F;
      repeat (4) @(posedge clk);
      reset_n <= 1'h1;
      repeat (3) @(posedge clk);
      for (int k = 0; k < 6; k++)
      begin
         apb(ctl + k[7:0], 1'h0, 8'h00);
         check8(rd, `DTEC_RST8);
      end
      apb(8'h90, 1'h0, 8'h00);
      check8({7'h0, err}, 8'h01);
      apb(mdr, 1'h1, 8'hA5);
      apb(mdr, 1'h0, 8'h00);
      check8(rd, 8'hA5);
      check8({7'h0, err}, 8'h00);
      check8({|prdata[31:8], 6'h0, pready}, 8'h01);
      $display("Test registers done");
      b = 8'h1A; // Twenty gap edges plus six bus edges with run set
      meas(lo0, 8'h01, 8'h10, 8'h00, 8'h00, 20, 1'h0);
      check8(ql, b);
      meas(lo0, 8'h01, 8'h10, 8'h00, 8'h00, 30, 1'h0);
      check8(ql, b + 8'h0A);
      meas(lo0, 8'h01, 8'h10, 8'hF8, 8'h12, 20, 1'h0);
      c16 = 16'h12F8 + {8'h00, b};
      check8(ql, c16[7:0]);
      check8(qh, c16[15:8]);
      meas(lo0, 8'h00, 8'h10, 8'hFC, 8'h12, 20, 1'h0);
      c13 = {8'h12, 5'h1C} + {5'h00, b};
      check8(ql, {3'h7, c13[4:0]});
      check8(qh, c13[12:5]);
      meas(lo0, 8'h02, 8'h10, 8'hF8, 8'hA0, 20, 1'h0);
      check8(ql, 8'hA0 + b - 8'h08);
      check8(qh, 8'hA0);
      check8(qc & 8'h20, 8'h20);
      meas(lo1, 8'h10, 8'h40, 8'h00, 8'h00, 20, 1'h0);
      check8(ql, b);
      meas(lo1, 8'h30, 8'h40, 8'h33, 8'h44, 20, 1'h0);
      check8(ql, 8'h33);
      check8(qh, 8'h44);
      meas(lo0, 8'h03, 8'h10, 8'hF8, 8'h66, 20, 1'h0);
      check8(ql, b - 8'h08);
      check8(qh, 8'h66);
      check8(qc & 8'hA0, 8'h20);
      meas(lo0, 8'h03, 8'h40, 8'h55, 8'hF8, 20, 1'h0);
      check8(ql, 8'h55);
      check8(qh, b - 8'h08);
      check8(qc & 8'hA0, 8'h80);
      meas(lo1, 8'h13, 8'h40, 8'hF8, 8'hFF, 20, 1'h0);
      check8(ql, b - 8'h08);
      check8(qh, 8'h00);
      check8(qc & 8'h80, 8'h00);
      $display("Test timer modes done");
      {extIrq0Pin_n, extIrq1Pin_n} <= 2'h0;
      meas(lo0, 8'h09, 8'h10, 8'h00, 8'h00, 20, 1'h0);
      check8(ql, 8'h00);
      meas(lo1, 8'h90, 8'h40, 8'h00, 8'h00, 20, 1'h0);
      check8(ql, 8'h00);
      {extIrq0Pin_n, extIrq1Pin_n} <= 2'h3;
      meas(lo0, 8'h09, 8'h10, 8'h00, 8'h00, 20, 1'h0);
      check8(ql, b);
      meas(lo0, 8'h05, 8'h10, 8'h00, 8'h00, 40, 1'h1);
      check8(ql, 8'h05);
      meas(lo1, 8'h50, 8'h40, 8'h00, 8'h00, 40, 1'h1);
      check8(ql, 8'h05);
      // Freeze: only the three bus edges after clkEn returns may count
      apb(ctl, 1'h1, 8'h10);
      clkEn <= 1'h0;
      repeat (30) @(posedge clk);
      clkEn <= 1'h1;
      apb(ctl, 1'h1, 8'h00);
      apb(lo0, 1'h0, 8'h00);
      check8(rd, 8'h08);
      $display("Test gating and events done");
      apb(lo0, 1'h1, 8'hFC);
      apb(lo1, 1'h1, 8'hFC);
      apb(lo0 + 8'h2, 1'h1, 8'h00);
      apb(lo1 + 8'h2, 1'h1, 8'h00);
      apb(mdr, 1'h1, 8'h22);
      apb(ctl, 1'h1, 8'h50);
      repeat (12) @(posedge clk);
      check8({4'h0, lines & 4'hA}, 8'h0A);
      ackEn <= 4'hA;
      repeat (8) @(posedge clk);
      check8({4'h0, lines & 4'hA}, 8'h00);
      ackEn <= 4'h0;
      apb(ctl, 1'h1, 8'h00);
      $display("Test timer acknowledge done");
      for (int k = 0; k < 2; k++)
      begin
         slowAck <= k[0];
         apb(ctl, 1'h1, 8'h01 << 2 * k);
         pin(k, 1'h0);
         repeat (6) @(posedge clk);
         pin(k, 1'h1);
         repeat (6) @(posedge clk);
         check8({7'h0, lines[2 * k]}, 8'h01);
         apb(ctl, 1'h0, 8'h00);
         check8(rd, 8'h03 << 2 * k);
         ackEn <= 4'h1 << 2 * k;
         repeat (12) @(posedge clk);
         check8({7'h0, lines[2 * k]}, 8'h00);
         apb(ctl, 1'h1, 8'h00);
         pin(k, 1'h0);
         repeat (20) @(posedge clk);
         check8({7'h0, lines[2 * k]}, 8'h01);
         pin(k, 1'h1);
         repeat (6) @(posedge clk);
         check8({7'h0, lines[2 * k]}, 8'h00);
         ackEn <= 4'h0;
      end
      $display("Test external requests done");
      tallyAndFinish;
   end
endmodule // dtec_timer_top_tb_top
`default_nettype wire
